// ### rtl/pmc_core.sv
/*
 * Decode and execution control for load/store with pointer
 * post-update and for the cache-management hint, with a classic
 * Wishbone slave for control and status.
 * Assumes: an in-order load/store unit whose ready promises a free
 * buffer line next cycle, a data TLB with two lookup ports and a
 * cache controller that reports completion of each hint.
 */
// The register offsets and the Wishbone slave port are this design's own decisions.
module pmc_core
   import pmc_pkg::*;
#(
   parameter bit   COMPRESS_SUPPORT = 1'b1
) (
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic            dec_valid,
   input  wire logic [31:0]     dec_instr,
   input  wire logic [XLEN-1:0] reg1_data,
   input  wire logic [XLEN-1:0] reg2_data,
   input  wire logic [XLEN-1:0] reg3_data,
   input  wire logic            reg3_zero,
   output      logic            dec_ready,
   output      pmc_lsu_req_s    lsu_req,
   input  wire logic            lsu_ready,
   input  wire pmc_lsu_rsp_s    lsu_rsp,
   output      logic [XLEN-1:0] acc_vaddr,
   input  wire logic            acc_tlb_miss,
   output      logic            ptr_chk_valid,
   output      logic [XLEN-1:0] ptr_chk_vaddr,
   input  wire logic            ptr_tlb_hit,
   output      logic            ptr_prefetch,
   output      pmc_wr_s         data_wr,
   output      pmc_wr_s         ptr_wr,
   output      pmc_fault_s      fault,
   output      pmc_cmm_s        cmm_cmd,
   input  wire logic            cmm_done,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output      logic [31:0]     wb_dat_o,
   output      logic            wb_ack_o
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // byte lanes covered by an item of the given size
   function automatic logic [7:0] size_mask(input logic [1:0] sz);
      size_mask = 8'((8'h01 << (4'(1) << sz)) - 8'h01);
   endfunction

   // low pointer bits that must be clear for the given size
   function automatic logic [2:0] align_mask(input logic [1:0] sz);
      logic [3:0] n;
      n          = 4'(4'h1 << sz);
      align_mask = 3'(n - 4'h1);
   endfunction

   function automatic logic [XLEN-1:0] trunc(input logic [XLEN-1:0] d,
                                             input logic [1:0] sz);
      logic [7:0]      m;
      logic [XLEN-1:0] r;
      m = size_mask(sz);
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if (m[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      trunc = r;
   endfunction

   function automatic logic [XLEN-1:0] swap(input logic [XLEN-1:0] d,
                                            input logic [1:0] sz);
      logic [XLEN-1:0] r;
      int              n;
      r = d;
      n = 1 << sz;
      for (int i = 0; i < 8; i++) begin
         if (i < n) begin
            r[8*i +: 8] = d[8*(n-1-i) +: 8];
         end
      end
      swap = r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decode

   logic [7:0] opc;
   logic [1:0] f_size;
   logic       f_big;
   logic [5:0] f_r1;
   logic [5:0] f_r2;
   logic       is_ld;
   logic       is_st;
   logic       is_cm;
   logic       accept;
   logic       null_ld;
   logic       misal;
   logic       do_acc;
   logic [1:0] ctrl;
   logic       cmm_busy;
   logic       mem_acc;

   assign opc    = dec_instr[OPC_LSB +: 8];
   assign f_size = dec_instr[SIZE_LSB +: 2];
   assign f_big  = dec_instr[ENDIAN_BIT];
   assign f_r1   = dec_instr[REG1_LSB +: 6];
   assign f_r2   = dec_instr[REG2_LSB +: 6];
   assign is_ld  = (opc == LOAD_OPCODE);
   assign is_st  = (opc == STORE_OPCODE);
   assign is_cm  = (opc == CACHE_HINT_OPCODE);
   assign accept = dec_valid & dec_ready;
   // accepted load or store, aligned or not
   assign mem_acc = accept & (is_ld | is_st);
   assign null_ld = is_ld & (f_r1 == 6'h00);
   // any significant low pointer bit set; bytes are never misaligned
   assign misal  = |(reg2_data[2:0] & align_mask(f_size));
   assign do_acc = mem_acc & (~misal | null_ld);

   ////////////////////////////////////////////////////////////////////
   // issue handshake: one access per cycle, stall without a free line

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dec_ready <= 1'b0;
      end else begin
         // lsu_ready promises a line for next cycle's request
         dec_ready <= lsu_ready & ~cmm_busy
                      & ~(accept & is_cm);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // memory request, one cycle after acceptance

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lsu_req   <= '0;
         acc_vaddr <= '0;
      end else begin
         lsu_req.valid    <= do_acc;
         lsu_req.we       <= is_st;
         lsu_req.prefetch <= null_ld;
         lsu_req.size     <= f_size;
         lsu_req.big      <= f_big;
         lsu_req.rd       <= f_r1;
         // a prefetch of a misaligned pointer is aligned down
         lsu_req.addr     <= reg2_data & ~XLEN'(align_mask(f_size));
         // store data leaves already sized and in memory order
         lsu_req.wdata    <= f_big ? swap(trunc(reg1_data, f_size),
                                          f_size)
                                   : trunc(reg1_data, f_size);
         if (accept) begin
            acc_vaddr <= reg2_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // load data write-back

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         data_wr <= '0;
      end else begin
         // a null destination is a prefetch and writes nothing
         data_wr.valid <= lsu_rsp.valid & (lsu_rsp.rd != 6'h00);
         data_wr.rd    <= lsu_rsp.rd;
         data_wr.data  <= trunc(lsu_rsp.big
                                ? swap(lsu_rsp.data, lsu_rsp.size)
                                : lsu_rsp.data, lsu_rsp.size);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fault detection

   logic p1_acc;
   logic p1_mis;
   logic p1_null;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         p1_acc  <= 1'b0;
         p1_mis  <= 1'b0;
         p1_null <= 1'b0;
      end else begin
         p1_acc  <= mem_acc;
         p1_mis  <= misal;
         p1_null <= null_ld;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault <= '0;
      end else begin
         fault.valid <= p1_acc & ~p1_null
                        & (p1_mis | acc_tlb_miss);
         fault.align <= p1_acc & ~p1_null & p1_mis;
         // page miss counts only on an aligned access
         fault.page  <= p1_acc & ~p1_null & ~p1_mis
                        & acc_tlb_miss;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pointer update: two adder stages, then the TLB stage

   logic [32:0]     s1_lo;
   logic [31:0]     s1_pa;
   logic [31:0]     s1_pb;
   logic            s1_upd;
   logic [5:0]      s1_rp;
   logic            s2_upd;
   logic [5:0]      s2_rp;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_lo  <= '0;
         s1_pa  <= '0;
         s1_pb  <= '0;
         s1_upd <= 1'b0;
         s1_rp  <= '0;
      end else begin
         // modular sum, carry of the low half kept for stage two
         s1_lo  <= 33'(reg2_data[31:0]) + 33'(reg3_data[31:0]);
         s1_pa  <= reg2_data[63:32];
         s1_pb  <= reg3_data[63:32];
         s1_upd <= mem_acc & ~reg3_zero
                   & (~misal | null_ld);
         s1_rp  <= f_r2;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ptr_chk_valid <= 1'b0;
         ptr_chk_vaddr <= '0;
         s2_upd        <= 1'b0;
         s2_rp         <= '0;
      end else begin
         ptr_chk_valid <= s1_upd;
         ptr_chk_vaddr <= {32'(s1_pa + s1_pb + 32'(s1_lo[32])),
                           s1_lo[31:0]};
         // a page fault on the access cancels its pointer write
         s2_upd        <= s1_upd & ~(p1_acc & ~p1_null & acc_tlb_miss);
         s2_rp         <= s1_rp;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ptr_wr       <= '0;
         ptr_prefetch <= 1'b0;
      end else begin
         ptr_wr.valid <= s2_upd;
         ptr_wr.rd    <= s2_rp;
         ptr_wr.data  <= ptr_chk_vaddr;
         ptr_prefetch <= ptr_chk_valid & ptr_tlb_hit
                         & ctrl[CTRL_PF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // cache-management hint, one outstanding at a time

   logic hint_nop;

   // the unused level is accepted and retired as a no-op
   assign hint_nop = dec_instr[LEVEL_LSB +: 3] == LEVEL_UNUSED;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmm_busy <= 1'b0;
         cmm_cmd  <= '0;
      end else begin
         if (accept & is_cm & ~hint_nop) begin
            cmm_busy         <= 1'b1;
            cmm_cmd.valid    <= 1'b1;
            cmm_cmd.prefetch <= dec_instr[DIR_BIT];
            cmm_cmd.lock     <= dec_instr[LOCK_BIT];
            cmm_cmd.compress <= dec_instr[COMP_BIT]
                                & COMPRESS_SUPPORT & ctrl[CTRL_CMP_BIT];
            cmm_cmd.level    <= dec_instr[LEVEL_LSB +: 3];
            cmm_cmd.start    <= reg2_data;
            cmm_cmd.length   <= reg1_data;
         end else if (cmm_done) begin
            cmm_busy      <= 1'b0;
            cmm_cmd.valid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register slave

   logic [15:0] fault_cnt;
   logic [1:0]  last_fault;
   logic        wb_hit;

   // a request is taken once; ack then blocks it for a cycle
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
      end else if (wb_hit & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == CTRL_ADDR)) begin
         ctrl <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_cnt  <= '0;
         last_fault <= '0;
      end else if (fault.valid) begin
         fault_cnt  <= 16'(fault_cnt + 16'h0001);
         last_fault <= {fault.page, fault.align};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_adr_i == CTRL_ADDR) begin
            wb_dat_o <= {30'h0, ctrl};
         end else if (wb_adr_i == STATUS_ADDR) begin
            wb_dat_o <= {29'h0, last_fault, cmm_busy};
         end else if (wb_adr_i == FAULTS_ADDR) begin
            wb_dat_o <= {16'h0, fault_cnt};
         end else begin
            wb_dat_o <= '0;
         end
      end
   end

endmodule

// ### rtl/pmc_pkg.sv
/*
 * Package of the post-increment memory and cache-hint decoder:
 * instruction fields, opcodes, size codes, register map and the
 * packed structs that travel between the decoder and its partners.
 * Assumes a 64-bit datapath and 32-bit instruction words.
 */
package pmc_pkg;

   localparam int          XLEN          = 64;
   // opcode values are plain defaults, adjust to the real map
   localparam logic [7:0]  LOAD_OPCODE   = 8'h40;
   localparam logic [7:0]  STORE_OPCODE  = 8'h41;
   localparam logic [7:0]  CACHE_HINT_OPCODE = 8'h42;

   localparam int          OPC_LSB       = 24;
   localparam int          SIZE_LSB      = 22;
   localparam int          ENDIAN_BIT    = 21;
   localparam int          HINT_LSB      = 18;
   localparam int          DIR_BIT       = 21;
   localparam int          LOCK_BIT      = 20;
   localparam int          COMP_BIT      = 19;
   localparam int          LEVEL_LSB     = 16;
   localparam int          REG3_LSB      = 12;
   localparam int          REG2_LSB      = 6;
   localparam int          REG1_LSB      = 0;

   // size code: 00 byte, 01 half, 10 word, 11 double
   localparam logic [1:0]  SIZE_BYTE     = 2'h0;
   localparam logic [2:0]  LEVEL_UNUSED  = 3'h3;

   localparam logic [7:0]  CTRL_ADDR     = 8'h00;
   localparam logic [7:0]  STATUS_ADDR   = 8'h04;
   localparam logic [7:0]  FAULTS_ADDR   = 8'h08;
   localparam int          CTRL_PF_BIT   = 0;
   localparam int          CTRL_CMP_BIT  = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h1;

   localparam int          ADD_CYCLES    = 2;
   localparam int          TLB_CYCLES    = 1;

   typedef struct packed {
      logic            valid;
      logic            we;
      logic            prefetch;
      logic [1:0]      size;
      logic            big;
      logic [5:0]      rd;
      logic [XLEN-1:0] addr;
      logic [XLEN-1:0] wdata;
   } pmc_lsu_req_s;

   typedef struct packed {
      logic            valid;
      logic [1:0]      size;
      logic            big;
      logic [5:0]      rd;
      logic [XLEN-1:0] data;
   } pmc_lsu_rsp_s;

   typedef struct packed {
      logic            valid;
      logic [5:0]      rd;
      logic [XLEN-1:0] data;
   } pmc_wr_s;

   typedef struct packed {
      logic            valid;
      logic            prefetch;
      logic            lock;
      logic            compress;
      logic [2:0]      level;
      logic [XLEN-1:0] start;
      logic [XLEN-1:0] length;
   } pmc_cmm_s;

   typedef struct packed {
      logic            valid;
      logic            align;
      logic            page;
   } pmc_fault_s;

endpackage

// ### testbench/pmc_checker.sv
/*
 * Concurrent checks on the ports of pmc_core: access issue, faults,
 * pointer update and cache-hint command timing.
 * Assumes the hand-over latencies and CTRL pointer prefetch left set.
 */
module pmc_checker
   import pmc_pkg::*;
(
   input wire logic            clock,
   input wire logic            rst,
   input wire logic            dec_valid,
   input wire logic [31:0]     dec_instr,
   input wire logic [XLEN-1:0] reg1_data,
   input wire logic [XLEN-1:0] reg2_data,
   input wire logic [XLEN-1:0] reg3_data,
   input wire logic            reg3_zero,
   input wire logic            dec_ready,
   input wire pmc_lsu_req_s    lsu_req,
   input wire logic            lsu_ready,
   input wire logic            acc_tlb_miss,
   input wire logic            ptr_chk_valid,
   input wire logic [XLEN-1:0] ptr_chk_vaddr,
   input wire pmc_wr_s         ptr_wr,
   input wire pmc_fault_s      fault,
   input wire pmc_cmm_s        cmm_cmd,
   input wire logic            cmm_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [XLEN-1:0] sum1, sum2, sum3;
   logic [31:0]     ins_q;
   logic            acc, ls, nul, mis, hint;

   assign acc  = dec_valid & dec_ready;
   assign ls   = dec_instr[31:24] == LOAD_OPCODE
               || dec_instr[31:24] == STORE_OPCODE;
   assign nul  = dec_instr[31:24] == LOAD_OPCODE && dec_instr[5:0] == 6'h0;
   assign mis  = |(reg2_data[2:0] & ((3'h1 << dec_instr[23:22]) - 3'h1));
   assign hint = acc && dec_instr[31:24] == CACHE_HINT_OPCODE;

   // operand sum delayed to the pointer check and write cycles
   always_ff @(posedge clock) begin
      sum1  <= reg2_data + reg3_data;
      sum2  <= sum1;
      sum3  <= sum2;
      ins_q <= dec_instr;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   align_fault_a: assert property (
      acc && ls && mis && !nul |=> !lsu_req.valid
      ##1 (fault.valid && fault.align && !fault.page) ##1 !ptr_wr.valid)
      else $error("misaligned access not refused");
   issue_a: assert property (
      acc && ls && !(mis && !nul) |=> lsu_req.valid
      && ($past(nul) || lsu_req.addr == $past(reg2_data)))
      else $error("accepted access not issued");
   null_pf_a: assert property (
      acc && nul |=> lsu_req.prefetch ##1 !fault.valid)
      else $error("null destination load faulted");
   ptr_sum_a: assert property (
      acc && ls && !nul && !reg3_zero && !mis
      |-> (##2 fault.valid) or (##3 ptr_wr.valid && ptr_wr.data == sum3))
      else $error("pointer update wrong");
   zero_stride_a: assert property (
      acc && ls && reg3_zero |-> ##2 !ptr_chk_valid ##1 !ptr_wr.valid)
      else $error("zero stride updated pointer");
   page_fault_a: assert property (
      lsu_req.valid && !lsu_req.prefetch && acc_tlb_miss
      |=> fault.valid && fault.page && !fault.align ##1 !ptr_wr.valid)
      else $error("page fault missing");
   tlb_chk_a: assert property (
      ptr_chk_valid |-> ptr_chk_vaddr == sum2)
      else $error("wrong pointer checked");
   hint_cmd_a: assert property (
      hint && dec_instr[18:16] != LEVEL_UNUSED |=> cmm_cmd.valid
      && cmm_cmd.start == $past(reg2_data)
      && cmm_cmd.length == $past(reg1_data)
      && cmm_cmd.level == ins_q[18:16] && cmm_cmd.lock == ins_q[LOCK_BIT]
      && cmm_cmd.prefetch == ins_q[DIR_BIT])
      else $error("hint command wrong");
   unused_lvl_a: assert property (
      hint && dec_instr[18:16] == LEVEL_UNUSED |=> !cmm_cmd.valid)
      else $error("unused level started a hint");
   hint_busy_a: assert property (
      cmm_cmd.valid |-> !dec_ready ##0 (cmm_done or ##1 cmm_cmd.valid))
      else $error("hint overlap or early release");
   stall_a: assert property (
      !lsu_ready |=> !dec_ready)
      else $error("accepted with no buffer line");
endmodule

bind pmc_core pmc_checker u_pmc_checker (.clock, .rst, .dec_valid,
   .dec_instr, .reg1_data, .reg2_data, .reg3_data, .reg3_zero, .dec_ready,
   .lsu_req, .lsu_ready, .acc_tlb_miss, .ptr_chk_valid, .ptr_chk_vaddr,
   .ptr_wr, .fault, .cmm_cmd, .cmm_done);

// ### testbench/pmc_lsu_model.sv
/*
 * Far side of pmc_core: load/store unit, data TLB and cache control.
 * Assumes the bench drives stall and the hint duration.
 */
module pmc_lsu_model
   import pmc_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic            stall,
   input  wire logic [7:0]      hint_wait,
   input  wire pmc_lsu_req_s    lsu_req,
   output      logic            lsu_ready,
   output      pmc_lsu_rsp_s    lsu_rsp,
   input  wire logic [XLEN-1:0] acc_vaddr,
   output      logic            acc_tlb_miss,
   input  wire logic [XLEN-1:0] ptr_chk_vaddr,
   output      logic            ptr_tlb_hit,
   input  wire pmc_cmm_s        cmm_cmd,
   output      logic            cmm_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) lsu_ready <= 1'b0;
      else lsu_ready <= !stall;
   end

   // unmapped pages have 0xA in address bits 47:44
   assign acc_tlb_miss = acc_vaddr[47:44] == 4'hA;
   assign ptr_tlb_hit  = ptr_chk_vaddr[47:44] != 4'hA;

   // answer in the request cycle; a missed access is dropped
   always_comb begin
      lsu_rsp.valid = lsu_req.valid & !lsu_req.we & !lsu_req.prefetch
                    & !acc_tlb_miss;
      lsu_rsp.size  = lsu_req.size;
      lsu_rsp.big   = lsu_req.big;
      lsu_rsp.rd    = lsu_req.rd;
      lsu_rsp.data  = (64'h0123456789ABCDEF + lsu_req.addr)
                    ^ {64{!lsu_rsp.valid}};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt      <= 8'h00;
         cmm_done <= 1'b0;
      end else begin
         cmm_done <= 1'b0;
         if (cmm_cmd.valid && !cmm_done) begin
            cnt <= cnt + 8'h01;
            if (cnt == hint_wait) begin
               cmm_done <= 1'b1;
               cnt      <= 8'h00;
            end
         end
      end
   end
endmodule

// ### testbench/tb.sv
/*
 * Directed bench for pmc_core with the far-side model.
 * Assumes the hand-over latencies; all inputs change at rising edges.
 */
module tb
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, dec_valid = 0, reg3_zero = 0, stall = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [31:0] dec_instr = '0, wb_dat_i = '0, wb_dat_o;
   logic [63:0] reg1_data = '0, reg2_data = '0, reg3_data = '0;
   logic [63:0] acc_vaddr, ptr_chk_vaddr;
   logic [7:0] wb_adr_i = '0, hint_wait = '0;
   logic [3:0] wb_sel_i = '0;
   logic dec_ready, lsu_ready, acc_tlb_miss, ptr_tlb_hit, ptr_chk_valid;
   logic ptr_prefetch, cmm_done, wb_ack_o;
   pmc_lsu_req_s lsu_req;
   pmc_lsu_rsp_s lsu_rsp;
   pmc_wr_s data_wr, ptr_wr;
   pmc_fault_s fault;
   pmc_cmm_s cmm_cmd;
   int err_total = 0, checks = 0, cyc = 0;

   always #4 clock = ~clock;

   pmc_core u_pmc_core (.clock, .rst, .dec_valid, .dec_instr, .reg1_data,
      .reg2_data, .reg3_data, .reg3_zero, .dec_ready, .lsu_req, .lsu_ready,
      .lsu_rsp, .acc_vaddr, .acc_tlb_miss, .ptr_chk_valid, .ptr_chk_vaddr,
      .ptr_tlb_hit, .ptr_prefetch, .data_wr, .ptr_wr, .fault, .cmm_cmd,
      .cmm_done, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o);
   pmc_lsu_model u_pmc_lsu_model (.clock, .rst, .stall, .hint_wait,
      .lsu_req, .lsu_ready, .lsu_rsp, .acc_vaddr, .acc_tlb_miss,
      .ptr_chk_vaddr, .ptr_tlb_hit, .cmm_cmd, .cmm_done);

   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         wrap_up;
      end
   end

   task chk(input logic c, input string m);
      checks++;
      if (c !== 1'b1) begin
         err_total++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask

   // truncate to the size code, byte-reversed when big
   function logic [63:0] fmt(input logic [63:0] v, input logic [1:0] sz,
                             input logic b);
      logic [63:0] r;
      int          n;
      r = '0;
      n = 1 << sz;
      for (int k = 0; k < n; k++) r[8*k+:8] = b ? v[8*(n-1-k)+:8] : v[8*k+:8];
      return r;
   endfunction

   // called at a rising edge; returns at the accepting edge, valid held
   task iss(input logic [31:0] i, input logic [63:0] a, p, s,
            input logic z);
      dec_valid <= 1'b1;
      dec_instr <= i;
      reg1_data <= a;
      reg2_data <= p;
      reg3_data <= s;
      reg3_zero <= z;
      do @(negedge clock); while (dec_ready !== 1'b1);
      @(posedge clock);
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, e,
           input string m);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      if (!w) chk(wb_dat_o === e, m);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task t_load;
      @(posedge clock);
      iss({LOAD_OPCODE, 6'h28, 6'h0, 6'h2, 6'h7}, 64'h0,
          64'hFFFF_FFFF_FFFF_FFF8, 64'h10, 1'b0);
      dec_valid <= 1'b0;
      @(negedge clock);
      chk(lsu_req.valid === 1'b1 && lsu_req.we === 1'b0, "load issue");
      @(negedge clock);
      chk(data_wr.valid === 1'b1 && data_wr.rd === 6'h7 && data_wr.data ===
          fmt(64'h0123456789ABCDEF - 64'h8, 2'h2, 1'b1), "load data");
      chk(ptr_chk_valid === 1'b1 && ptr_chk_vaddr === 64'h8, "tlb check");
      @(negedge clock);
      chk(ptr_wr.valid === 1'b1 && ptr_wr.rd === 6'h2 &&
          ptr_wr.data === 64'h8 && ptr_prefetch === 1'b1, "pointer");
   endtask

   task t_store;
      @(posedge clock);
      iss({STORE_OPCODE, 6'h10, 6'h4, 6'h3, 6'h1}, 64'h1122334455667788,
          64'h2000, 64'hFFFF_FFFF_FFFF_FFFE, 1'b0);
      iss({STORE_OPCODE, 6'h38, 6'h4, 6'h3, 6'h1}, 64'h1122334455667788,
          64'h2008, 64'h8, 1'b0);
      dec_valid <= 1'b0;
      @(negedge clock);
      chk(lsu_req.valid === 1'b1 && lsu_req.we === 1'b1 &&
          lsu_req.addr === 64'h2008 &&
          lsu_req.wdata === 64'h8877665544332211, "store issue");
      @(negedge clock);
      chk(ptr_wr.valid === 1'b1 && ptr_wr.data === 64'h1FFE, "ptr one");
      @(negedge clock);
      chk(ptr_wr.valid === 1'b1 && ptr_wr.data === 64'h2010, "ptr two");
   endtask

   task t_flt(input logic [31:0] i, input logic [63:0] p,
              input logic rq, a, pg, z);
      @(posedge clock);
      iss(i, 64'h55, p, 64'h8, z);
      dec_valid <= 1'b0;
      @(negedge clock);
      chk(lsu_req.valid === rq, "access issue");
      @(negedge clock);
      chk(fault.valid === (a | pg) && data_wr.valid === 1'b0 &&
          (!(a | pg) || (fault.align === a && fault.page === pg)), "fault");
      @(negedge clock);
      chk(ptr_wr.valid === (rq & ~pg & ~z) &&
          (!(rq & ~pg & ~z) || ptr_wr.data === p + 64'h8), "pointer");
   endtask

   task t_hint;
      for (int l = 0; l < 8; l++) begin
         @(posedge clock);
         hint_wait <= 8'(l);
         iss({CACHE_HINT_OPCODE, 2'h0, l[0], l[1], l[2], 3'(l), 4'h0, 6'h2,
              6'h1}, 64'h100 + 64'(l), 64'h4000, 64'h0, 1'b0);
         dec_valid <= 1'b0;
         @(negedge clock);
         if (l == 3) chk(cmm_cmd.valid === 1'b0, "unused level");
         else begin
            chk(cmm_cmd.valid === 1'b1 && cmm_cmd.level === 3'(l) &&
                cmm_cmd.prefetch === l[0] && cmm_cmd.lock === l[1] &&
                cmm_cmd.compress === l[2] && cmm_cmd.start === 64'h4000 &&
                cmm_cmd.length === 64'h100 + 64'(l), "hint command");
            do @(negedge clock); while (cmm_done !== 1'b1);
            @(negedge clock);
            chk(cmm_cmd.valid === 1'b0, "hint release");
         end
      end
   endtask

   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      wb(1'b0, CTRL_ADDR, 32'h0, 32'h1, "ctrl reset");
      wb(1'b1, CTRL_ADDR, 32'h3, 32'h0, "");
      wb(1'b0, CTRL_ADDR, 32'h0, 32'h3, "ctrl write");
      wb(1'b0, 8'h0C, 32'h0, 32'h0, "unmapped read");
      t_load;
      t_store;
      t_flt({LOAD_OPCODE, 6'h20, 6'h4, 6'h2, 6'h7}, 64'h1002, 0, 1, 0, 0);
      t_flt({LOAD_OPCODE, 6'h30, 6'h4, 6'h2, 6'h7}, 64'hA000_0000_0004,
            0, 1, 0, 0);
      t_flt({LOAD_OPCODE, 6'h30, 6'h4, 6'h2, 6'h7}, 64'hA000_0000_0008,
            1, 0, 1, 0);
      t_flt({LOAD_OPCODE, 6'h30, 6'h4, 6'h2, 6'h0}, 64'hA000_0000_0003,
            1, 0, 0, 1);
      t_flt({STORE_OPCODE, 6'h10, 6'h9, 6'h2, 6'h1}, 64'h1001, 0, 1, 0, 0);
      t_flt({STORE_OPCODE, 6'h10, 6'h9, 6'h2, 6'h1}, 64'h1000, 1, 0, 0, 1);
      wb(1'b0, FAULTS_ADDR, 32'h0, 32'h4, "fault count");
      wb(1'b1, STATUS_ADDR, 32'h7, 32'h0, "");
      wb(1'b0, STATUS_ADDR, 32'h0, 32'h2, "status");
      @(posedge clock);
      stall <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(dec_ready === 1'b0, "stall");
      @(posedge clock);
      stall <= 1'b0;
      t_load;
      t_hint;
      wrap_up;
   end
endmodule
